//--- core/usb_tfc_pkg.sv
// Package: register map, field layout and timing constants for the token and frame control block
package usb_tfc_pkg;

    // ========================================
    // Register byte offsets
    localparam logic [7:0] MODULE_CONTROL_OFF = 8'h00;
    localparam logic [7:0] DEVICE_ADDRESS_OFF = 8'h04;
    localparam logic [7:0] FRAME_LOW_OFF = 8'h08;
    localparam logic [7:0] FRAME_HIGH_OFF = 8'h0C;
    localparam logic [7:0] TOKEN_COMMAND_OFF = 8'h10;

    // ========================================
    // Control register bit positions; LOW_SPEED_POS is bit 7 of the address register
    localparam int MODULE_ENABLE_POS = 0;
    localparam int PINGPONG_RESET_POS = 1;
    localparam int RESUME_POS = 2;
    localparam int HOST_ENABLE_POS = 3;
    localparam int TOKEN_BUSY_POS = 5;
    localparam int LOW_SPEED_POS = 7;

    // ========================================
    // Reset values
    localparam logic [7:0] CONTROL_RESET = 8'h00;
    localparam logic [7:0] ADDRESS_RESET = 8'h00;
    localparam logic [7:0] TOKEN_RESET = 8'h00;
    localparam logic [10:0] FRAME_RESET = 11'h000;

    // ========================================
    // Token type codes
    localparam logic [3:0] PID_OUT = 4'h1;
    localparam logic [3:0] PID_IN = 4'h9;
    localparam logic [3:0] PID_SETUP = 4'hD;

    // ========================================
    // Timing
    localparam int CLOCK_HZ = 50_000_000;
    localparam int FRAME_PERIOD_US = 1000;
    localparam int FRAME_CYCLES = CLOCK_HZ / 1_000_000 * FRAME_PERIOD_US;
    localparam int TOKEN_CYCLES = 64;
    localparam int EOP_CYCLES = 8;

    // ========================================
    // Carriers
    typedef struct packed {
        logic [3:0] pid;
        logic [3:0] endpoint;
        logic [6:0] address;
        logic low_speed;
    } token_req_t;

    typedef enum logic [1:0] {
        HOST_IDLE = 2'b00,
        HOST_TOKEN = 2'b01,
        HOST_EOP = 2'b10
    } host_state_t;

endpackage : usb_tfc_pkg

//--- core/usb_token_frame_control.sv
// Token, frame and control register block with an AXI4-Lite slave
//
// Added by the designer: the address map and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps

// ========================================
// Summary of operation
// - Ping-pong reset write returns pointers to even
// - Device mode: bit 0 enables module
// - Host mode: bit 0 sends SOF each 1 ms
// - Host enable toggle resets host logic
// - Host resume clear appends low-speed EOP when the token sequencer is idle
// - Address bit 7 selects low speed token
// - Seven-bit device address, resets to zero
// - Frame number split low eight, high three
// - Received SOF loads frame number registers
// - Token PID codes OUT, IN, SETUP
// - Token busy set while token executes
// - Host enable bit enables host capability
module usb_token_frame_control
    import usb_tfc_pkg::*;
#(
    parameter int FRAME_COUNT = FRAME_CYCLES
)
(
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire logic ce_i,
    input wire logic [7:0] s_axi_awaddr_i,
    input wire logic s_axi_awvalid_i,
    output logic s_axi_awready_o,
    input wire logic [31:0] s_axi_wdata_i,
    input wire logic [3:0] s_axi_wstrb_i,
    input wire logic s_axi_wvalid_i,
    output logic s_axi_wready_o,
    output logic [1:0] s_axi_bresp_o,
    output logic s_axi_bvalid_o,
    input wire logic s_axi_bready_i,
    input wire logic [7:0] s_axi_araddr_i,
    input wire logic s_axi_arvalid_i,
    output logic s_axi_arready_o,
    output logic [31:0] s_axi_rdata_o,
    output logic [1:0] s_axi_rresp_o,
    output logic s_axi_rvalid_o,
    input wire logic s_axi_rready_i,
    input wire logic sof_rx_i,
    input wire logic [10:0] sof_frame_i,
    input wire logic token_done_i,
    output logic module_enable_o,
    output logic host_mode_o,
    output logic host_reset_o,
    output logic pingpong_pointer_reset_o,
    output logic sof_send_o,
    output logic resume_drive_o,
    output logic low_speed_eop_o,
    output logic token_start_o,
    output token_req_t token_req_o
);

    // ========================================
    // Synchronisers for link-side event inputs
    logic sof_rx_m, sof_rx_s;
    logic done_m, done_s;
    logic [10:0] frame_m, frame_s;

    always_ff @(posedge clk_i)
    begin
        if (!rst_b_i)
        begin
            sof_rx_m <= 1'b0;
            sof_rx_s <= 1'b0;
            done_m <= 1'b0;
            done_s <= 1'b0;
            frame_m <= FRAME_RESET;
            frame_s <= FRAME_RESET;
        end
        else if (ce_i)
        begin
            sof_rx_m <= sof_rx_i;
            sof_rx_s <= sof_rx_m;
            done_m <= token_done_i;
            done_s <= done_m;
            frame_m <= sof_frame_i;
            frame_s <= frame_m;
        end
    end

    logic sof_rx_d;
    always_ff @(posedge clk_i)
    begin
        if (!rst_b_i)
            sof_rx_d <= 1'b0;
        else if (ce_i)
            sof_rx_d <= sof_rx_s;
    end
    logic sof_rx_pulse;
    assign sof_rx_pulse = sof_rx_s & ~sof_rx_d;

    // ========================================
    // AXI4-Lite write channel: address and data taken in either order
    logic aw_held, w_held;
    logic [7:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic wr_fire;

    assign wr_fire = aw_held & w_held & ~s_axi_bvalid_o;

    always_ff @(posedge clk_i)
    begin
        if (!rst_b_i)
        begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr <= 8'h00;
            w_data <= 32'h0000_0000;
            w_strb <= 4'h0;
            s_axi_awready_o <= 1'b0;
            s_axi_wready_o <= 1'b0;
            s_axi_bvalid_o <= 1'b0;
            s_axi_bresp_o <= 2'b00;
        end
        else if (ce_i)
        begin
            s_axi_awready_o <= ~aw_held & ~s_axi_awready_o & s_axi_awvalid_i;
            s_axi_wready_o <= ~w_held & ~s_axi_wready_o & s_axi_wvalid_i;
            if (s_axi_awvalid_i && s_axi_awready_o)
            begin
                aw_held <= 1'b1;
                aw_addr <= s_axi_awaddr_i;
            end
            if (s_axi_wvalid_i && s_axi_wready_o)
            begin
                w_held <= 1'b1;
                w_data <= s_axi_wdata_i;
                w_strb <= s_axi_wstrb_i;
            end
            if (wr_fire)
            begin
                aw_held <= 1'b0;
                w_held <= 1'b0;
                s_axi_bvalid_o <= 1'b1;
                s_axi_bresp_o <= (aw_addr[7:2] <= TOKEN_COMMAND_OFF[7:2]) ? 2'b00 : 2'b10;
            end
            else if (s_axi_bready_i)
                s_axi_bvalid_o <= 1'b0;
        end
    end

    logic wr_ctrl, wr_addr, wr_tok;
    assign wr_ctrl = wr_fire & w_strb[0] & (aw_addr[7:2] == MODULE_CONTROL_OFF[7:2]);
    assign wr_addr = wr_fire & w_strb[0] & (aw_addr[7:2] == DEVICE_ADDRESS_OFF[7:2]);
    assign wr_tok = wr_fire & w_strb[0] & (aw_addr[7:2] == TOKEN_COMMAND_OFF[7:2]);

    // ========================================
    // Control and address registers
    logic [7:0] device_address_reg;
    logic [7:0] token_command_reg;
    logic token_in_progress;
    logic [10:0] frame_number;

    always_ff @(posedge clk_i)
    begin
        if (!rst_b_i)
        begin
            module_enable_o <= CONTROL_RESET[MODULE_ENABLE_POS];
            host_mode_o <= CONTROL_RESET[HOST_ENABLE_POS];
            resume_drive_o <= CONTROL_RESET[RESUME_POS];
            pingpong_pointer_reset_o <= CONTROL_RESET[PINGPONG_RESET_POS];
            host_reset_o <= 1'b0;
        end
        else if (ce_i)
        begin
            pingpong_pointer_reset_o <= wr_ctrl & w_data[PINGPONG_RESET_POS];
            host_reset_o <= wr_ctrl & (w_data[HOST_ENABLE_POS] != host_mode_o);
            if (wr_ctrl)
            begin
                module_enable_o <= w_data[MODULE_ENABLE_POS];
                host_mode_o <= w_data[HOST_ENABLE_POS];
                resume_drive_o <= w_data[RESUME_POS];
            end
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (!rst_b_i)
            device_address_reg <= ADDRESS_RESET;
        else if (ce_i && wr_addr)
            device_address_reg <= w_data[7:0];
    end

    always_ff @(posedge clk_i)
    begin
        if (!rst_b_i)
            frame_number <= FRAME_RESET;
        else if (ce_i && sof_rx_pulse)
            frame_number <= frame_s;
    end

    // ========================================
    // Host SOF generator; the bit doubles as module enable outside host mode
    logic [$clog2(FRAME_COUNT)-1:0] frame_timer;
    always_ff @(posedge clk_i)
    begin
        if (!rst_b_i || (ce_i && host_reset_o))
        begin
            frame_timer <= '0;
            sof_send_o <= 1'b0;
        end
        else if (ce_i)
        begin
            sof_send_o <= 1'b0;
            if (!host_mode_o || !module_enable_o)
                frame_timer <= '0;
            else if (frame_timer == $clog2(FRAME_COUNT)'(FRAME_COUNT - 1))
            begin
                frame_timer <= '0;
                sof_send_o <= 1'b1;
            end
            else
                frame_timer <= frame_timer + 1'b1;
        end
    end

    // ========================================
    // Host token sequencer and resume end-of-packet
    host_state_t state;
    logic [7:0] phase_count;

    always_ff @(posedge clk_i)
    begin
        if (!rst_b_i || (ce_i && host_reset_o))
        begin
            state <= HOST_IDLE;
            phase_count <= 8'h00;
            token_command_reg <= TOKEN_RESET;
            token_in_progress <= 1'b0;
            token_start_o <= 1'b0;
            token_req_o <= '0;
            low_speed_eop_o <= 1'b0;
        end
        else if (ce_i)
        begin
            token_start_o <= 1'b0;
            if (wr_tok)
                token_command_reg <= w_data[7:0];
            unique case (state)
                HOST_IDLE:
                begin
                    low_speed_eop_o <= 1'b0;
                    if (host_mode_o && wr_ctrl && resume_drive_o && !w_data[RESUME_POS])
                    begin
                        state <= HOST_EOP;
                        phase_count <= 8'h00;
                        low_speed_eop_o <= 1'b1;
                    end
                    else if (host_mode_o && wr_tok && !token_in_progress)
                    begin
                        state <= HOST_TOKEN;
                        phase_count <= 8'h00;
                        token_in_progress <= 1'b1;
                        token_start_o <= 1'b1;
                        token_req_o.pid <= w_data[7:4];
                        token_req_o.endpoint <= w_data[3:0];
                        token_req_o.address <= device_address_reg[6:0];
                        token_req_o.low_speed <= device_address_reg[LOW_SPEED_POS];
                    end
                end
                HOST_TOKEN:
                begin
                    // Ends on the link's completion or a bounded timeout so busy never sticks
                    if (done_s || phase_count == 8'(TOKEN_CYCLES - 1))
                    begin
                        state <= HOST_IDLE;
                        token_in_progress <= 1'b0;
                    end
                    else
                        phase_count <= phase_count + 1'b1;
                end
                HOST_EOP:
                begin
                    if (phase_count == 8'(EOP_CYCLES - 1))
                    begin
                        state <= HOST_IDLE;
                        low_speed_eop_o <= 1'b0;
                    end
                    else
                        phase_count <= phase_count + 1'b1;
                end
                default:
                    state <= HOST_IDLE;
            endcase
        end
    end

    // ========================================
    // AXI4-Lite read channel
    logic [31:0] next_rdata;
    always_comb
    begin
        next_rdata = 32'h0000_0000;
        unique case (s_axi_araddr_i[7:2])
            MODULE_CONTROL_OFF[7:2]:
                next_rdata[7:0] = {2'b00, token_in_progress, 1'b0, host_mode_o, resume_drive_o, 1'b0,
                                   module_enable_o};
            DEVICE_ADDRESS_OFF[7:2]: next_rdata[7:0] = device_address_reg;
            FRAME_LOW_OFF[7:2]: next_rdata[7:0] = frame_number[7:0];
            FRAME_HIGH_OFF[7:2]: next_rdata[2:0] = frame_number[10:8];
            TOKEN_COMMAND_OFF[7:2]: next_rdata[7:0] = token_command_reg;
            default: next_rdata = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge clk_i)
    begin
        if (!rst_b_i)
        begin
            s_axi_arready_o <= 1'b0;
            s_axi_rvalid_o <= 1'b0;
            s_axi_rdata_o <= 32'h0000_0000;
            s_axi_rresp_o <= 2'b00;
        end
        else if (ce_i)
        begin
            s_axi_arready_o <= ~s_axi_arready_o & ~s_axi_rvalid_o & s_axi_arvalid_i;
            if (s_axi_arvalid_i && s_axi_arready_o)
            begin
                s_axi_rvalid_o <= 1'b1;
                s_axi_rdata_o <= next_rdata;
                s_axi_rresp_o <= (s_axi_araddr_i[7:2] <= TOKEN_COMMAND_OFF[7:2]) ? 2'b00 : 2'b10;
            end
            else if (s_axi_rready_i)
                s_axi_rvalid_o <= 1'b0;
        end
    end

    // ========================================
    // Checks
    sequence tok_write_s;
        wr_tok && host_mode_o && !token_in_progress && state == HOST_IDLE && !wr_ctrl;
    endsequence

    ppb_pulse_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        (ce_i && wr_ctrl && w_data[PINGPONG_RESET_POS]) |=> pingpong_pointer_reset_o)
        else $error("ping-pong reset pulse missing");
    enable_follow_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        (ce_i && wr_ctrl) |=> module_enable_o == $past(w_data[MODULE_ENABLE_POS]))
        else $error("module enable not written");
    sof_gated_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        sof_send_o |-> $past(host_mode_o) && $past(module_enable_o))
        else $error("SOF sent while disabled");
    host_toggle_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        (ce_i && $changed(host_mode_o)) |-> host_reset_o)
        else $error("host toggle without host reset");
    resume_eop_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        low_speed_eop_o && !$past(low_speed_eop_o) |-> !resume_drive_o && host_mode_o)
        else $error("EOP without resume clear");
    token_launch_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        (ce_i and tok_write_s) |=> token_start_o && token_in_progress)
        else $error("token write did not launch");
    busy_bound_a: assert property (@(posedge clk_i) disable iff (!rst_b_i || !ce_i)
        $rose(token_in_progress) |-> ##[1:70] !token_in_progress)
        else $error("token busy stuck");
    frame_load_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        (ce_i && sof_rx_pulse && !host_reset_o) |=> frame_number == $past(frame_s))
        else $error("frame number not loaded");

endmodule : usb_token_frame_control

//--- verification/usb_link_partner.sv
// Far side of the USB link: answers token launches and delivers received frame starts
`timescale 1ns/1ps
module usb_link_partner
(
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire logic token_start_i,
    input wire logic [7:0] delay_i,
    input wire logic sof_go_i,
    input wire logic [10:0] sof_num_i,
    output logic token_done_o,
    output logic sof_rx_o,
    output logic [10:0] sof_frame_o
);
    int tok_cnt;
    int sof_cnt;

    // ========================================
    // Token completion after a chosen delay, prompt or slow
    always @(posedge clk_i)
    begin
        token_done_o <= 1'b0;
        if (!rst_b_i)
            tok_cnt <= 0;
        else if (token_start_i)
            tok_cnt <= delay_i;
        else if (tok_cnt == 1)
        begin
            token_done_o <= 1'b1;
            tok_cnt <= 0;
        end
        else if (tok_cnt > 1)
            tok_cnt <= tok_cnt - 1;
    end

    // ========================================
    // Frame start; number held while the flag is high, then scrambled
    always @(posedge clk_i)
    begin
        if (!rst_b_i)
        begin
            sof_cnt <= 0;
            sof_rx_o <= 1'b0;
            sof_frame_o <= 11'h5A5;
        end
        else if (sof_go_i)
        begin
            sof_rx_o <= 1'b1;
            sof_frame_o <= sof_num_i;
            sof_cnt <= 6;
        end
        else if (sof_cnt == 1)
        begin
            sof_rx_o <= 1'b0;
            sof_frame_o <= ~sof_frame_o;
            sof_cnt <= 0;
        end
        else if (sof_cnt > 1)
            sof_cnt <= sof_cnt - 1;
    end
endmodule : usb_link_partner

//--- verification/usb_otg_token_frame_control_tb_top.sv
// Self-checking testbench for the token, frame and control block
`timescale 1ns/1ps
module usb_otg_token_frame_control_tb_top;
    import usb_tfc_pkg::*;
    // Short frame so several frame starts fit in the run
    localparam int FC = 20;
    logic clk_i = 1'b0;
    logic rst_b_i = 1'b0;
    logic [7:0] awa = 8'h00;
    logic [7:0] ara = 8'h00;
    logic [7:0] dly = 8'h0A;
    logic [31:0] wd = 32'h0;
    logic [10:0] snum = 11'h000;
    logic awv = 1'b0;
    logic wv = 1'b0;
    // Response ready held high throughout; the slave answers when it likes
    logic bry = 1'b1;
    logic arv = 1'b0;
    logic rry = 1'b1;
    logic sgo = 1'b0;
    logic ce = 1'b1;
    logic awr, wr_o, bv, arr, rv, me, hm, hr, pp, ss, rsm, eop, ts, done, srx;
    logic [1:0] bresp;
    logic [1:0] rresp;
    logic [31:0] rdo;
    logic [10:0] sfr;
    token_req_t treq;
    token_req_t cap;
    int num_errors = 0;
    int samples_checked = 0;
    int pp_n = 0, hr_n = 0, ss_n = 0, ts_n = 0, eop_n = 0, cyc = 0, last_ss = 0;
    int mdl [5] = '{0, 0, 0, 0, 0};

    always #10 clk_i = ~clk_i;

    usb_token_frame_control #(.FRAME_COUNT(FC)) usb_token_frame_control_i (.clk_i(clk_i), .rst_b_i(rst_b_i),
        .ce_i(ce), .s_axi_awaddr_i(awa), .s_axi_awvalid_i(awv), .s_axi_awready_o(awr), .s_axi_wdata_i(wd),
        .s_axi_wstrb_i(4'hF), .s_axi_wvalid_i(wv), .s_axi_wready_o(wr_o), .s_axi_bresp_o(bresp),
        .s_axi_bvalid_o(bv), .s_axi_bready_i(bry), .s_axi_araddr_i(ara), .s_axi_arvalid_i(arv),
        .s_axi_arready_o(arr), .s_axi_rdata_o(rdo), .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rv),
        .s_axi_rready_i(rry), .sof_rx_i(srx), .sof_frame_i(sfr), .token_done_i(done), .module_enable_o(me),
        .host_mode_o(hm), .host_reset_o(hr), .pingpong_pointer_reset_o(pp), .sof_send_o(ss),
        .resume_drive_o(rsm), .low_speed_eop_o(eop), .token_start_o(ts), .token_req_o(treq));

    usb_link_partner usb_link_partner_i (.clk_i(clk_i), .rst_b_i(rst_b_i), .token_start_i(ts), .delay_i(dly),
        .sof_go_i(sgo), .sof_num_i(snum), .token_done_o(done), .sof_rx_o(srx), .sof_frame_o(sfr));

    // ========================================
    // Checking and closing
    task automatic check(input logic [63:0] got, input logic [63:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            num_errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check

    task automatic complete_run();
        $display("errors=%0d checks=%0d", num_errors, samples_checked);
        if (num_errors == 0 && samples_checked > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : complete_run

    task automatic guard(input int n);
        if (n >= 50)
        begin
            num_errors++;
            complete_run();
        end
    endtask : guard

    // Pulse counters; frame starts must be exactly one frame apart
    always @(posedge clk_i)
    begin
        cyc++;
        pp_n += pp;
        hr_n += hr;
        ts_n += ts;
        eop_n += eop;
        if (ts)
            cap = treq;
        if (ss)
        begin
            ss_n++;
            if (last_ss > 0)
                check(cyc - last_ss, FC);
            last_ss = cyc;
        end
    end

    // ========================================
    // Bus master tasks
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        awa <= a;
        wd <= d;
        awv <= 1'b1;
        wv <= 1'b1;
        do
        begin
            @(posedge clk_i);
            n++;
            if (awr)
                awv <= 1'b0;
            if (wr_o)
                wv <= 1'b0;
        end while (!bv && n < 50);
        guard(n);
        check(bresp, (a <= TOKEN_COMMAND_OFF) ? 2'b00 : 2'b10);
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        int n;
        n = 0;
        ara <= a;
        arv <= 1'b1;
        do
        begin
            @(posedge clk_i);
            n++;
            if (arr)
                arv <= 1'b0;
        end while (!rv && n < 50);
        d = rdo;
        r = rresp;
        guard(n);
    endtask : rd

    task automatic rc(input logic [7:0] a);
        logic [31:0] d;
        logic [1:0] r;
        rd(a, d, r);
        check({r, d}, {2'b00, 32'(mdl[a / 4])});
    endtask : rc

    // Software waits for token busy to clear before a new token
    task automatic wait_idle();
        logic [31:0] d;
        logic [1:0] r;
        int n;
        n = 0;
        do
        begin
            rd(MODULE_CONTROL_OFF, d, r);
            n++;
        end while (d[TOKEN_BUSY_POS] && n < 50);
        guard(n);
    endtask : wait_idle

    // ========================================
    // Main sequence
    initial
    begin
        logic [31:0] d;
        logic [1:0] r;
        logic [3:0] pids [3];
        int f;
        int a;
        pids = '{PID_OUT, PID_IN, PID_SETUP};
        void'($urandom(76));
        repeat (5) @(posedge clk_i);
        rst_b_i <= 1'b1;
        for (int i = 0; i < 5; i++)
            rc(8'(i * 4));
        rd(8'h14, d, r);
        check({r, d}, {2'b10, 32'h0});
        wr(8'h14, 32'hFF);
        a = $urandom;
        wr(DEVICE_ADDRESS_OFF, a);
        mdl[1] = a & 255;
        rc(DEVICE_ADDRESS_OFF);
        wr(MODULE_CONTROL_OFF, 32'h03);
        mdl[0] = 1;
        rc(MODULE_CONTROL_OFF);
        check(pp_n, 1);
        check(me, 1);
        wr(MODULE_CONTROL_OFF, 32'h01);
        repeat (3 * FC) @(posedge clk_i);
        check(pp_n, 1);
        check(ss_n, 0);
        wr(MODULE_CONTROL_OFF, 32'h08);
        repeat (2) @(posedge clk_i);
        check({me, hm, hr_n[3:0]}, 6'h11);
        wr(MODULE_CONTROL_OFF, 32'h09);
        repeat (5 * FC) @(posedge clk_i);
        check(ss_n >= 4, 1);
        wr(MODULE_CONTROL_OFF, 32'h08);
        f = ss_n;
        repeat (2 * FC) @(posedge clk_i);
        check(ss_n, f);
        // Every token code, alternating speed, link delay of 10 to 39 cycles, always inside the token timeout
        for (int i = 0; i < 3; i++)
        begin
            a = $urandom % 128;
            wr(DEVICE_ADDRESS_OFF, {i[0], 7'(a)});
            wait_idle();
            dly <= 8'(10 + $urandom % 30);
            f = $urandom % 16;
            wr(TOKEN_COMMAND_OFF, {pids[i], 4'(f)});
            mdl[4] = pids[i] * 16 + f;
            repeat (2) @(posedge clk_i);
            check(ts_n, i + 1);
            check(cap, {pids[i], 4'(f), 7'(a), i[0]});
            rd(MODULE_CONTROL_OFF, d, r);
            check(d[TOKEN_BUSY_POS], 1);
            rc(TOKEN_COMMAND_OFF);
            wait_idle();
        end
        // Resume held only briefly; its real hold time is too long to simulate
        f = eop_n;
        wr(MODULE_CONTROL_OFF, 32'h0C);
        check(rsm, 1);
        wr(MODULE_CONTROL_OFF, 32'h08);
        // Frozen cycles stretch the end-of-packet, the output holding meanwhile
        ce <= 1'b0;
        repeat (5) @(posedge clk_i);
        ce <= 1'b1;
        repeat (12) @(posedge clk_i);
        check(eop_n - f, EOP_CYCLES + 5);
        f = $urandom % 2048;
        snum <= 11'(f);
        sgo <= 1'b1;
        @(posedge clk_i);
        sgo <= 1'b0;
        repeat (8) @(posedge clk_i);
        mdl[2] = f % 256;
        mdl[3] = f / 256;
        rc(FRAME_LOW_OFF);
        rc(FRAME_HIGH_OFF);
        wr(FRAME_LOW_OFF, 32'hFF);
        rc(FRAME_LOW_OFF);
        wr(MODULE_CONTROL_OFF, 32'h00);
        repeat (2) @(posedge clk_i);
        check({hm, hr_n[3:0]}, 5'h02);
        complete_run();
    end
endmodule : usb_otg_token_frame_control_tb_top
